/* include/power_monitor_pkg.sv */
package power_monitor_pkg;
	// converter phase, gray along idle -> sense -> rail
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SENSE = 2'b01,
		PH_RAIL  = 2'b11
	} conv_phase_t;

	typedef logic [15:0] reg16_t;
	typedef logic [7:0]  cmd_code_t;
	typedef logic [2:0]  field3_t;
endpackage

/* include/power_monitor_regs.svh */
`ifndef POWER_MONITOR_REGS_SVH
`define POWER_MONITOR_REGS_SVH

// command codes
`define CMD_MODE_CONFIG     8'h00
`define CMD_SENSE_DROP      8'h01
`define CMD_RAIL_LEVEL      8'h02
`define CMD_WATTS           8'h03
`define CMD_AMPS            8'h04
`define CMD_SCALE_FACTOR    8'h05
`define CMD_WARNING_MASK    8'h06
`define CMD_WARNING_THRESH  8'h07
`define CMD_MAKER_CODE      8'hFE
`define CMD_SILICON_CODE    8'hFF

// reset values
`define MODE_CONFIG_RST     16'h4127
`define RESULT_RST          16'h0000
`define RW_REG_RST          16'h0000
`define UNMAPPED_READ       16'h0000

// configuration field positions
`define CFG_SOFT_RST_BIT    15
`define CFG_AVG_MSB         11
`define CFG_AVG_LSB         9
`define CFG_RAIL_CT_MSB     8
`define CFG_RAIL_CT_LSB     6
`define CFG_SENSE_CT_MSB    5
`define CFG_SENSE_CT_LSB    3
`define CFG_OP_MSB          2
`define CFG_OP_LSB          0
// op select: bit0 sense, bit1 rail, bit2 continuous
`define OP_SENSE_BIT        0
`define OP_RAIL_BIT         1
`define OP_CONT_BIT         2

// conversion times in microseconds, codes 0..7
`define CT_US_0             14'd139
`define CT_US_1             14'd203
`define CT_US_2             14'd269
`define CT_US_3             14'd525
`define CT_US_4             14'd1037
`define CT_US_5             14'd2061
`define CT_US_6             14'd4109
`define CT_US_7             14'd8205

// averaging sample counts, codes 0..7
`define AVG_N_0             11'd1
`define AVG_N_1             11'd4
`define AVG_N_2             11'd16
`define AVG_N_3             11'd64
`define AVG_N_4             11'd128
`define AVG_N_5             11'd256
`define AVG_N_6             11'd512
`define AVG_N_7             11'd1024

// timing base
`define CLK_PERIOD_NS       10
`define US_NS               1000
`define US_CYCLES_DFLT      (`US_NS / `CLK_PERIOD_NS)

`endif

/* tb/host_model.sv */
module host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rd_byte_i,
	output logic            cmd_valid_o,
	output logic            wr_byte_valid_o,
	output logic            rd_byte_req_o,
	output logic            xfer_end_o,
	output logic [7:0]      byte_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0; // idle cycles between bus events, for a slow host
	initial {cmd_valid_o, wr_byte_valid_o, rd_byte_req_o, xfer_end_o} = 4'h0;
	initial byte_o = 8'h00;
	// one bus event for one edge; the byte lane then shows the inverted byte
	task automatic beat(input logic [3:0] k, input logic [7:0] b);
		@(posedge clk_i);
		{cmd_valid_o, wr_byte_valid_o, rd_byte_req_o, xfer_end_o} <= k;
		byte_o <= b;
		@(posedge clk_i);
		{cmd_valid_o, wr_byte_valid_o, rd_byte_req_o, xfer_end_o} <= 4'h0;
		byte_o <= ~b;
		repeat (gap) @(posedge clk_i);
	endtask
	// command byte, then the word high byte first, then stop
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		beat(4'h8, c);
		beat(4'h4, d[15:8]);
		beat(4'h4, d[7:0]);
		beat(4'h1, 8'h00);
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		beat(4'h8, c);
		beat(4'h2, 8'h00);
		#1 d[15:8] = rd_byte_i;
		beat(4'h2, 8'h00);
		#1 d[7:0] = rd_byte_i;
		beat(4'h1, 8'h00);
	endtask
endmodule

/* tb/power_monitor_register_bank_properties.sv */
module power_monitor_register_bank_properties #(
	parameter logic [15:0] MAKER_CODE = 16'h0A5C // arbitrary value
) (
	input wire logic                          clk_i,
	input wire logic                          sys_rst_i,
	input wire logic                          cmd_valid_i,
	input wire power_monitor_pkg::cmd_code_t  cmd_code_i,
	input wire logic                          wr_byte_valid_i,
	input wire logic [7:0]                    wr_byte_i,
	input wire logic                          rd_byte_req_i,
	input wire logic                          xfer_end_i,
	input wire logic [7:0]                    rd_byte_o,
	input wire power_monitor_pkg::field3_t    sample_average_select_o,
	input wire power_monitor_pkg::field3_t    op_select_o,
	input wire power_monitor_pkg::reg16_t     scale_factor_o,
	input wire power_monitor_pkg::conv_phase_t conv_phase_o,
	input wire logic                          conv_halted_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import power_monitor_pkg::*;
	logic [7:0] ptr;
	logic [7:0] hi;
	logic       odd;
	logic       rd1;
	wire lo_wr = wr_byte_valid_i && odd && !cmd_valid_i && !xfer_end_i;
	// host view of pointer and byte phase; a lone byte dies at stop
	always_ff @(posedge clk_i)
		if (sys_rst_i) ptr <= 8'h00;
		else if (cmd_valid_i) ptr <= cmd_code_i;
	always_ff @(posedge clk_i)
		if (sys_rst_i || cmd_valid_i || xfer_end_i) odd <= 1'b0;
		else if (wr_byte_valid_i) {odd, hi} <= {!odd, wr_byte_i};
	// first read after a command returns the high byte
	always_ff @(posedge clk_i)
		rd1 <= !sys_rst_i && (cmd_valid_i || rd1 && !rd_byte_req_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	reset_default_a: assert property ($fell(sys_rst_i) |->
		{sample_average_select_o, op_select_o} == 6'h07 &&
		scale_factor_o == 16'h0000) else $error("bad reset value");
	halt_set_a: assert property (wr_byte_valid_i && !odd &&
		!cmd_valid_i && !xfer_end_i && ptr == 8'h00 |=> conv_halted_o)
		else $error("no halt on config write");
	halt_idle_a: assert property (conv_halted_o |=>
		conv_phase_o == PH_IDLE) else $error("converting while halted");
	halt_end_a: assert property (conv_halted_o && xfer_end_i &&
		!wr_byte_valid_i && op_select_o[1:0] != 2'b00 |=>
		!conv_halted_o ##[1:4] conv_phase_o != PH_IDLE)
		else $error("no restart after config write");
	mode_phase_a: assert property (conv_phase_o != PH_IDLE |->
		op_select_o[conv_phase_o[1]]) else $error("phase not selected");
	cfg_write_a: assert property (lo_wr && ptr == 8'h00 && !hi[7]
		|=> {sample_average_select_o, op_select_o} ==
		{$past(hi[3:1]), $past(wr_byte_i[2:0])})
		else $error("config fields wrong");
	soft_reset_a: assert property (lo_wr && ptr == 8'h00 && hi[7]
		|=> {sample_average_select_o, op_select_o} == 6'h07 &&
		scale_factor_o == 16'h0000) else $error("soft reset missed");
	cal_write_a: assert property (lo_wr && ptr == 8'h05 |=>
		scale_factor_o == {$past(hi), $past(wr_byte_i)})
		else $error("calibration write lost");
	id_read_a: assert property (rd_byte_req_i && rd1 && ptr == 8'hFE
		|=> rd_byte_o == MAKER_CODE[15:8]) else $error("bad id byte");
	read_quiet_a: assert property (rd_byte_req_i && !wr_byte_valid_i &&
		!conv_halted_o |=> !conv_halted_o && $stable(op_select_o))
		else $error("read disturbed config");
	cover property (lo_wr && ptr == 8'h00 && hi[7]);
	cover property (conv_halted_o ##1 !conv_halted_o);
	cover property (conv_phase_o == PH_RAIL);
endmodule
bind power_monitor_register_bank power_monitor_register_bank_properties
	#(.MAKER_CODE(MAKER_CODE)) u_props (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
	.cmd_code_i(cmd_code_i), .wr_byte_valid_i(wr_byte_valid_i),
	.wr_byte_i(wr_byte_i), .rd_byte_req_i(rd_byte_req_i),
	.xfer_end_i(xfer_end_i), .rd_byte_o(rd_byte_o),
	.sample_average_select_o(sample_average_select_o),
	.op_select_o(op_select_o), .scale_factor_o(scale_factor_o),
	.conv_phase_o(conv_phase_o), .conv_halted_o(conv_halted_o));

/* tb/power_monitor_register_bank_tb.sv */
module power_monitor_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import power_monitor_pkg::*;
	localparam logic [15:0] MAKER   = 16'h5A31; // arbitrary value
	localparam logic [15:0] SILICON = 16'h3C07; // arbitrary value
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        meas_valid_i = 1'b0;
	reg16_t      meas_i = 16'h0000;
	logic        cmd_valid, wr_valid, rd_req, xfer_end;
	logic        sample_done, pass_done, halted;
	logic [7:0]  bus_byte, rd_byte;
	field3_t     avg_sel, op_sel;
	field3_t     rail_ct, sense_ct;
	reg16_t      mask, thresh;
	reg16_t      scale, w;
	conv_phase_t phase;
	int          fail_count = 0;
	int          compares = 0;
	power_monitor_register_bank #(.US_CYCLES(2), .MAKER_CODE(MAKER),
		.SILICON_CODE(SILICON)) u_power_monitor_register_bank (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid),
		.cmd_code_i(bus_byte), .wr_byte_valid_i(wr_valid),
		.wr_byte_i(bus_byte), .rd_byte_req_i(rd_req),
		.xfer_end_i(xfer_end), .meas_valid_i(meas_valid_i),
		.sense_meas_i(meas_i), .rail_meas_i(~meas_i),
		.watts_meas_i(meas_i ^ 16'h0F0F),
		.amps_meas_i({meas_i[7:0], meas_i[15:8]}), .rd_byte_o(rd_byte),
		.sample_average_select_o(avg_sel), .rail_conv_time_o(rail_ct),
		.sense_conv_time_o(sense_ct), .op_select_o(op_sel),
		.scale_factor_o(scale), .warning_mask_control_o(mask),
		.warning_threshold_o(thresh), .conv_phase_o(phase),
		.sample_done_o(sample_done), .pass_done_o(pass_done),
		.conv_halted_o(halted));
	host_model u_host_model (.clk_i(clk_i), .rd_byte_i(rd_byte),
		.cmd_valid_o(cmd_valid), .wr_byte_valid_o(wr_valid),
		.rd_byte_req_o(rd_req), .xfer_end_o(xfer_end), .byte_o(bus_byte));
	initial forever #5 clk_i = ~clk_i;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic timed_out();
		fail_count++;
		give_verdict();
	endtask
	// codes 00..07, FE, FF and one unmapped code
	function automatic logic [7:0] code_of(input int i);
		return i < 8 ? 8'(i) : i < 10 ? 8'hF6 + 8'(i) : 8'h08;
	endfunction
	// defaults, then a write to every code but 00; only three writable keep it
	task automatic s_regs();
		logic [15:0] d;
		for (int i = 0; i < 11; i++) begin
			d = i == 0 ? 16'h4127 : i == 8 ? MAKER : i == 9 ? SILICON : 16'h0000;
			u_host_model.rd(code_of(i), w);
			check(w, d);
			if (i == 0) continue;
			u_host_model.wr(code_of(i), 16'hC35A ^ 16'(i));
			u_host_model.rd(code_of(i), w);
			check(w, i > 4 && i < 8 ? 16'hC35A ^ 16'(i) : d);
			if (i == 6 || i == 7)
				check(i == 6 ? mask : thresh, 16'hC35A ^ 16'(i));
		end
	endtask
	// every averaging code; halt rises on the first data byte
	task automatic s_config();
		for (int a = 0; a < 8; a++) begin
			u_host_model.beat(4'h8, 8'h00);
			u_host_model.beat(4'h4, {4'h0, 3'(a), 1'b1});
			#1 check(16'(halted), 16'h0001);
			u_host_model.beat(4'h4, 8'h27);
			u_host_model.beat(4'h1, 8'h00);
			u_host_model.rd(8'h00, w);
			check(w, {4'h0, 3'(a), 9'h127});
			check(16'(avg_sel), 16'(a));
			check({10'h000, rail_ct, sense_ct}, 16'h0024);
		end
	endtask
	// one triggered pass per setting: samples times conversion time
	task automatic s_timing();
		reg16_t cfg [4] = '{16'h0001, 16'h0201, 16'h0039, 16'h00FA};
		int n [4] = '{278, 1112, 16410, 1050};
		int ns [4] = '{1, 4, 1, 1};
		int k, s;
		for (int t = 0; t < 4; t++) begin
			u_host_model.wr(8'h00, cfg[t]);
			s = 0;
			for (k = 0; k < 20000 && pass_done !== 1'b1; k++) begin
				@(posedge clk_i);
				#1 s += 32'(sample_done);
			end
			if (k == 20000) timed_out();
			check(16'(k >= n[t] && k <= n[t] + 6), 16'h0001);
			check(16'(s), 16'(ns[t]));
			repeat (4) @(posedge clk_i);
			check(16'(phase), 16'(PH_IDLE));
		end
	endtask
	// soft reset through the config register restores the config and scale factor defaults
	task automatic s_soft();
		u_host_model.wr(8'h05, 16'h1234);
		check(scale, 16'h1234);
		u_host_model.wr(8'h00, 16'h8000);
		u_host_model.rd(8'h00, w);
		check(w, 16'h4127);
		u_host_model.rd(8'h05, w);
		check(w, 16'h0000);
		check(scale, 16'h0000);
	endtask
	// results load mid conversion; a config read leaves it running
	task automatic s_meas();
		int k;
		for (k = 0; k < 50 && phase === PH_IDLE; k++) @(posedge clk_i);
		if (k == 50) timed_out();
		@(posedge clk_i);
		meas_valid_i <= 1'b1;
		meas_i <= 16'h8421;
		@(posedge clk_i);
		meas_valid_i <= 1'b0;
		u_host_model.rd(8'h00, w);
		#1 check(16'(halted), 16'h0000);
		check(16'(phase == PH_IDLE), 16'h0000);
		for (int i = 1; i < 5; i++) begin
			u_host_model.rd(8'(i), w);
			check(w, i == 1 ? 16'h8421 : i == 2 ? 16'h7BDE :
				i == 3 ? 16'h8B2E : 16'h2184);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		u_host_model.gap = 2;
		s_regs();
		u_host_model.gap = 0;
		s_config();
		s_timing();
		s_soft();
		s_meas();
		give_verdict();
	end
endmodule

/* verilog/conv_pacer.sv */
`include "power_monitor_regs.svh"

module conv_pacer (
	input  wire logic                            clk_i,
	input  wire logic                            sys_rst_i,
	input  wire logic                            run_i,
	input  wire logic                            restart_i,
	input  wire logic                            us_tick_i,
	input  wire power_monitor_pkg::field3_t      op_select_i,
	input  wire power_monitor_pkg::field3_t      avg_select_i,
	input  wire power_monitor_pkg::field3_t      sense_ct_i,
	input  wire power_monitor_pkg::field3_t      rail_ct_i,
	output power_monitor_pkg::conv_phase_t       conv_phase_o,
	output logic                                 sample_done_o,
	output logic                                 pass_done_o
);
	import power_monitor_pkg::*;

	conv_phase_t  phase;
	logic [13:0]  us_cnt;
	logic [10:0]  avg_cnt;
	logic         conv_end;
	logic         last_sample;
	logic         next_round;
	conv_phase_t  next_phase;

	// conversion time code to microseconds
	function automatic logic [13:0] conv_us(input field3_t code);
		unique case (code)
			3'h0: conv_us = `CT_US_0;
			3'h1: conv_us = `CT_US_1;
			3'h2: conv_us = `CT_US_2;
			3'h3: conv_us = `CT_US_3;
			3'h4: conv_us = `CT_US_4;
			3'h5: conv_us = `CT_US_5;
			3'h6: conv_us = `CT_US_6;
			3'h7: conv_us = `CT_US_7;
		endcase
	endfunction

	// averaging code to sample count
	function automatic logic [10:0] avg_n(input field3_t code);
		unique case (code)
			3'h0: avg_n = `AVG_N_0;
			3'h1: avg_n = `AVG_N_1;
			3'h2: avg_n = `AVG_N_2;
			3'h3: avg_n = `AVG_N_3;
			3'h4: avg_n = `AVG_N_4;
			3'h5: avg_n = `AVG_N_5;
			3'h6: avg_n = `AVG_N_6;
			3'h7: avg_n = `AVG_N_7;
		endcase
	endfunction

	// current conversion ends on the last microsecond tick
	always_comb begin
		conv_end = 1'b0;
		if (phase == PH_SENSE)
			conv_end = us_tick_i && (us_cnt == conv_us(sense_ct_i) - 14'd1);
		else if (phase == PH_RAIL)
			conv_end = us_tick_i && (us_cnt == conv_us(rail_ct_i) - 14'd1);
	end

	// sample completes after rail, or after sense when rail is off
	assign sample_done_o = conv_end &&
		(phase == PH_RAIL || !op_select_i[`OP_RAIL_BIT]);
	assign last_sample = avg_cnt == avg_n(avg_select_i) - 11'd1;
	assign pass_done_o = sample_done_o && last_sample;
	// triggered mode stops after one averaged pass
	assign next_round  = !(last_sample && !op_select_i[`OP_CONT_BIT]);
	assign conv_phase_o = phase;

	// first phase of a sample, by the selected signals
	always_comb begin
		if (op_select_i[`OP_SENSE_BIT])
			next_phase = PH_SENSE;
		else if (op_select_i[`OP_RAIL_BIT])
			next_phase = PH_RAIL;
		else
			next_phase = PH_IDLE;
	end

	// phase sequencing; a halt drops straight to idle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !run_i) begin
			phase <= PH_IDLE;
		end else if (restart_i) begin
			phase <= next_phase;
		end else begin
			unique case (phase)
				PH_IDLE: phase <= PH_IDLE;
				PH_SENSE: begin
					if (conv_end && op_select_i[`OP_RAIL_BIT])
						phase <= PH_RAIL;
					else if (conv_end)
						phase <= next_round ? next_phase : PH_IDLE;
				end
				PH_RAIL: begin
					if (conv_end)
						phase <= next_round ? next_phase : PH_IDLE;
				end
				default: phase <= PH_IDLE;
			endcase
		end
	end

	// microsecond count inside one conversion
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !run_i || restart_i || conv_end)
			us_cnt <= 14'd0;
		else if (us_tick_i && phase != PH_IDLE)
			us_cnt <= us_cnt + 14'd1;
	end

	// samples gathered toward one averaged result
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !run_i || restart_i || pass_done_o)
			avg_cnt <= 11'd0;
		else if (sample_done_o)
			avg_cnt <= avg_cnt + 11'd1;
	end
endmodule

/* verilog/power_monitor_register_bank.sv */
// Contract
// - all registers 16 bits, moved as two bytes, picked by 8-bit command code
// - config reads never alter settings nor disturb a running conversion
// - config write halts conversion until transfer ends, then restarts fresh
// - writing config bit 15 as 1 restores all defaults; bit self-clears
// - config bits 11:9 pick 1,4,16,64,128,256,512,1024 averaged samples
// - config at code 00h is read-write, resets to 4127h
// - config layout: reset, unused 14:12, averaging, rail time, sense time, mode
// - config bits 1:0 pick which signals are converted, bit 2 picks continuous
// - code 01h returns sense measurement, read-only, resets to zero
// - code 02h returns rail measurement, read-only, resets to zero
// - each conversion time code picks 139 to 8205 microseconds, default 1037
`include "power_monitor_regs.svh"

module power_monitor_register_bank #(
	parameter int unsigned US_CYCLES    = `US_CYCLES_DFLT,
	parameter logic [15:0] MAKER_CODE   = 16'h0A5C, // arbitrary value
	parameter logic [15:0] SILICON_CODE = 16'h03C1  // arbitrary value
) (
	input  wire logic                            clk_i,
	input  wire logic                            sys_rst_i,
	input  wire logic                            cmd_valid_i,
	input  wire power_monitor_pkg::cmd_code_t    cmd_code_i,
	input  wire logic                            wr_byte_valid_i,
	input  wire logic [7:0]                      wr_byte_i,
	input  wire logic                            rd_byte_req_i,
	input  wire logic                            xfer_end_i,
	input  wire logic                            meas_valid_i,
	input  wire power_monitor_pkg::reg16_t       sense_meas_i,
	input  wire power_monitor_pkg::reg16_t       rail_meas_i,
	input  wire power_monitor_pkg::reg16_t       watts_meas_i,
	input  wire power_monitor_pkg::reg16_t       amps_meas_i,
	output logic [7:0]                           rd_byte_o,
	output power_monitor_pkg::field3_t           sample_average_select_o,
	output power_monitor_pkg::field3_t           rail_conv_time_o,
	output power_monitor_pkg::field3_t           sense_conv_time_o,
	output power_monitor_pkg::field3_t           op_select_o,
	output power_monitor_pkg::reg16_t            scale_factor_o,
	output power_monitor_pkg::reg16_t            warning_mask_control_o,
	output power_monitor_pkg::reg16_t            warning_threshold_o,
	output power_monitor_pkg::conv_phase_t       conv_phase_o,
	output logic                                 sample_done_o,
	output logic                                 pass_done_o,
	output logic                                 conv_halted_o
);
	import power_monitor_pkg::*;

	cmd_code_t   cmd_ptr;
	logic        wr_phase;
	logic [7:0]  wr_hi;
	logic        rd_phase;
	logic [7:0]  rd_lo;
	logic        wr_commit;
	logic        soft_rst;
	logic        bank_rst;
	logic        halt;
	logic        restart;
	logic [15:0] us_div;
	logic        us_tick;
	reg16_t      wr_word;
	reg16_t      rd_word;
	reg16_t      mode_config;
	reg16_t      sense_drop_result;
	reg16_t      rail_level_result;
	reg16_t      watts_result;
	reg16_t      amps_result;
	reg16_t      scale_factor;
	reg16_t      warning_mask_control;
	reg16_t      warning_threshold;

	// second data byte completes a 16-bit write, high byte first
	assign wr_word   = {wr_hi, wr_byte_i};
	assign wr_commit = wr_byte_valid_i && wr_phase;
	assign soft_rst  = wr_commit && cmd_ptr == `CMD_MODE_CONFIG &&
		wr_word[`CFG_SOFT_RST_BIT];
	assign bank_rst  = sys_rst_i || soft_rst;

	// command pointer; a new command restarts the byte pairing
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			cmd_ptr <= `CMD_MODE_CONFIG;
		else if (cmd_valid_i)
			cmd_ptr <= cmd_code_i;
	end

	// write byte pairing
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || cmd_valid_i || xfer_end_i) begin
			wr_phase <= 1'b0;
			wr_hi    <= 8'h00;
		end else if (wr_byte_valid_i) begin
			wr_phase <= !wr_phase;
			if (!wr_phase)
				wr_hi <= wr_byte_i;
		end
	end

	// configuration; the reset bit is never stored so it reads zero
	always_ff @(posedge clk_i) begin
		if (bank_rst)
			mode_config <= `MODE_CONFIG_RST;
		else if (wr_commit && cmd_ptr == `CMD_MODE_CONFIG)
			mode_config <= {1'b0, wr_word[14:0]};
	end

	// read-write working registers
	always_ff @(posedge clk_i) begin
		if (bank_rst) begin
			scale_factor         <= `RW_REG_RST;
			warning_mask_control <= `RW_REG_RST;
			warning_threshold    <= `RW_REG_RST;
		end else if (wr_commit) begin
			if (cmd_ptr == `CMD_SCALE_FACTOR)
				scale_factor <= wr_word;
			if (cmd_ptr == `CMD_WARNING_MASK)
				warning_mask_control <= wr_word;
			if (cmd_ptr == `CMD_WARNING_THRESH)
				warning_threshold <= wr_word;
		end
	end

	// results load only from the measurement path, host writes ignored
	always_ff @(posedge clk_i) begin
		if (bank_rst) begin
			sense_drop_result <= `RESULT_RST;
			rail_level_result <= `RESULT_RST;
			watts_result      <= `RESULT_RST;
			amps_result       <= `RESULT_RST;
		end else if (meas_valid_i) begin
			sense_drop_result <= sense_meas_i;
			rail_level_result <= rail_meas_i;
			watts_result      <= watts_meas_i;
			amps_result       <= amps_meas_i;
		end
	end

	// read selection; pure mux so reads have no side effect
	always_comb begin
		unique case (cmd_ptr)
			`CMD_MODE_CONFIG:    rd_word = mode_config;
			`CMD_SENSE_DROP:     rd_word = sense_drop_result;
			`CMD_RAIL_LEVEL:     rd_word = rail_level_result;
			`CMD_WATTS:          rd_word = watts_result;
			`CMD_AMPS:           rd_word = amps_result;
			`CMD_SCALE_FACTOR:   rd_word = scale_factor;
			`CMD_WARNING_MASK:   rd_word = warning_mask_control;
			`CMD_WARNING_THRESH: rd_word = warning_threshold;
			`CMD_MAKER_CODE:     rd_word = MAKER_CODE;
			`CMD_SILICON_CODE:   rd_word = SILICON_CODE;
			default:             rd_word = `UNMAPPED_READ;
		endcase
	end

	// read bytes; low byte snapped with high so a word never tears
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || cmd_valid_i || xfer_end_i) begin
			rd_phase <= 1'b0;
		end else if (rd_byte_req_i) begin
			rd_phase <= !rd_phase;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_byte_o <= 8'h00;
			rd_lo     <= 8'h00;
		end else if (rd_byte_req_i && !rd_phase) begin
			rd_byte_o <= rd_word[15:8];
			rd_lo     <= rd_word[7:0];
		end else if (rd_byte_req_i) begin
			rd_byte_o <= rd_lo;
		end
	end

	// halt from first config data byte to end of transfer; set wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			halt <= 1'b0;
		else if (wr_byte_valid_i && cmd_ptr == `CMD_MODE_CONFIG)
			halt <= 1'b1;
		else if (xfer_end_i)
			halt <= 1'b0;
	end

	// fresh conversion one cycle after release, or out of reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			restart <= 1'b1;
		else
			restart <= halt && xfer_end_i &&
				!(wr_byte_valid_i && cmd_ptr == `CMD_MODE_CONFIG);
	end

	// microsecond enable; realigned on restart so the first microsecond
	// of a fresh conversion is never cut short
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || us_tick || restart)
			us_div <= 16'd0;
		else
			us_div <= us_div + 16'd1;
	end
	assign us_tick = us_div == 16'(US_CYCLES - 1);

	conv_pacer u_pacer (
		.clk_i         (clk_i),
		.sys_rst_i     (sys_rst_i),
		.run_i         (!halt),
		.restart_i     (restart),
		.us_tick_i     (us_tick),
		.op_select_i   (mode_config[`CFG_OP_MSB:`CFG_OP_LSB]),
		.avg_select_i  (mode_config[`CFG_AVG_MSB:`CFG_AVG_LSB]),
		.sense_ct_i    (mode_config[`CFG_SENSE_CT_MSB:`CFG_SENSE_CT_LSB]),
		.rail_ct_i     (mode_config[`CFG_RAIL_CT_MSB:`CFG_RAIL_CT_LSB]),
		.conv_phase_o  (conv_phase_o),
		.sample_done_o (sample_done_o),
		.pass_done_o   (pass_done_o)
	);

	// settings to the converter and arithmetic
	assign sample_average_select_o = mode_config[`CFG_AVG_MSB:`CFG_AVG_LSB];
	assign rail_conv_time_o  = mode_config[`CFG_RAIL_CT_MSB:`CFG_RAIL_CT_LSB];
	assign sense_conv_time_o = mode_config[`CFG_SENSE_CT_MSB:`CFG_SENSE_CT_LSB];
	assign op_select_o            = mode_config[`CFG_OP_MSB:`CFG_OP_LSB];
	assign scale_factor_o         = scale_factor;
	assign warning_mask_control_o = warning_mask_control;
	assign warning_threshold_o    = warning_threshold;
	assign conv_halted_o          = halt;
endmodule
